/* File: core/sccd_pkg.sv */
// shared constants of the system clock domain control block
package sccd_pkg;

    // register byte offsets on the 32-bit wishbone port
    localparam logic [7:0] ADR_PLL_CTRL = 8'h00; // pll_control_reg_one
    localparam logic [7:0] ADR_CLK_CFG = 8'h04; // clock_config_reg_two
    localparam logic [7:0] ADR_PERI_GATE = 8'h08; // peripheral_gate_reg_one
    localparam logic [7:0] ADR_IDLE_CFG = 8'h0c; // cpu idle gate register
    localparam logic [7:0] ADR_USB_CTRL = 8'h10; // usb_system_control_reg
    localparam logic [7:0] ADR_CPU_ST3 = 8'h14; // cpu_status_reg_three
    localparam logic [7:0] ADR_STATUS = 8'h18; // read-only status

    // field positions, all in byte lane 0
    localparam int BIT_PLL_POWERDOWN = 0;
    localparam int BIT_MAIN_SYSTEM_CLOCK_SOURCE = 0;
    localparam int BIT_MASTER_STOP = 0;
    localparam int BIT_CPU_IDLE_GATE = 0;
    localparam int BIT_USB_OSC_EN = 0;
    localparam int BIT_DEBUG_CLOCK_OFF = 0;
    localparam int ST_REF_EXTERNAL = 0;
    localparam int ST_BYPASS_ON = 1;
    localparam int ST_PLL_ON = 2;
    localparam int ST_PLL_LOCKED = 3;
    localparam int ST_MAIN_SYSTEM_CLOCK_STOPPED = 4;
    localparam int ST_CPU_GATED = 5;
    localparam int ST_RTC_OSC_OK = 6;
    localparam int ST_WIDTH = 7;

    // reset values
    localparam logic RST_PLL_POWERDOWN = 1'h1;
    localparam logic RST_MAIN_SYSTEM_CLOCK_SOURCE = 1'h0;
    localparam logic RST_MASTER_STOP = 1'h0;
    localparam logic RST_CPU_IDLE_GATE = 1'h0;
    localparam logic RST_USB_OSC_EN = 1'h0;
    localparam logic RST_DEBUG_CLOCK_OFF = 1'h0;

    // pin index in the synchroniser vector
    localparam int PIN_REF_SEL = 0;
    localparam int PIN_WAKE = 1;
    localparam int PIN_EXTERNAL_INTERRUPT_PIN_ZERO = 2;
    localparam int PIN_EXTERNAL_INTERRUPT_PIN_ONE = 3;
    localparam int PIN_RTC_IRQ = 4;
    localparam int PIN_RTC_OSC = 5;
    localparam int PIN_COUNT = 6;

    // straps are caught this many cycles after reset release
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // pll lock wait
    localparam int CLK_MHZ = 125;
    localparam int PLL_LOCK_TIME_US = 4000;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLK_MHZ;

    // bypass/pll mux states, break-before-make
    typedef enum logic [3:0] {
        SCCD_MUX_BYPASS = 4'h1,
        SCCD_MUX_TO_PLL = 4'h2,
        SCCD_MUX_PLL = 4'h4,
        SCCD_MUX_TO_BYPASS = 4'h8
    } sccd_mux_t;

endpackage

/* File: core/sccd_clock_gate.sv */
`timescale 1ns/1ns
`default_nettype none
// latch-based gate: enable only changes while the clock is low
module sccd_clock_gate (
    input wire logic clk_in,
    input wire logic enable,
    output wire logic clk_out
);
    logic en_latched;

    // transparent low latch, so a change never cuts a high phase short
    always_latch begin
        if (!clk_in) begin
            en_latched <= enable;
        end
    end

    assign clk_out = clk_in & en_latched; // RQ17
endmodule // sccd_clock_gate
`default_nettype wire

/* File: core/sccd_top.sv */
// Contract
// (RQ1) reference clock is external pin or rtc oscillator, chosen by select pin
// (RQ2) board holds the select pin fixed after reset release
// (RQ3) bypass lets the selected reference drive the system clock directly
// (RQ4) usb oscillator off after reset until software enables it
// (RQ5) usb oscillator can never become the system reference
// (RQ6) writing 1 to pll power-down stops the pll
// (RQ7) software bypasses before powering the pll down
// (RQ8) pll selection refused while powered down; power-down never blocked
// (RQ9) master stop bit halts the main system clock
// (RQ10) wake, external_interrupt_pin_zero, external_interrupt_pin_one or rtc interrupt restart a stopped system clock
// (RQ11) idle gate bit gates only the cpu clock, on the idle instruction
// (RQ12) any unmasked interrupt restores a gated cpu clock
// (RQ13) debug clock off bit disables the debug clock pin driver
// (RQ14) without rtc oscillator the rtc neither runs nor is accessible
// (RQ15) bypass/pll switch is glitch free, no short pulses
// (RQ16) software waits 4 ms in bypass after power-up before pll select
// (RQ17) every clock gate is a latch-based glitch-free gate
`timescale 1ns/1ns
`default_nettype none
module sccd_top #(
    parameter int LOCK_CYCLES = sccd_pkg::PLL_LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ref_source_select_pin,
    input wire logic rtc_osc_present_pin,
    input wire logic wake_pin,
    input wire logic external_interrupt_pin_zero,
    input wire logic external_interrupt_pin_one,
    input wire logic rtc_interrupt,
    input wire logic idle_instruction,
    input wire logic unmasked_irq,
    output logic ref_from_external,
    output logic bypass_clock_enable,
    output logic pll_clock_enable,
    output logic pll_powerdown,
    output logic pll_locked,
    output logic usb_osc_enable,
    output logic rtc_run,
    output logic main_clock_enable,
    output logic cpu_clock_enable,
    output wire logic main_system_clock,
    output wire logic cpu_clock,
    output logic debug_clock_pin_o,
    output logic debug_clock_pin_oe_n
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYCLES);
    localparam int PN = sccd_pkg::PIN_COUNT;

    localparam int ST_WIDTH_L = sccd_pkg::ST_WIDTH;
    // every check below runs on the root clock, off while in reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    typedef struct packed {
        logic [PN-1:0] s1, s2, s3;
        logic [1:0] strap_cnt;
        logic ref_ext, rtc_ok;
        logic pll_pd, src_bit, master_stop, idle_bit, usb_en, dbg_off;
        logic cpu_gated;
        sccd_pkg::sccd_mux_t mux;
        logic byp_en, pll_en, main_en, cpu_en;
        logic [LW-1:0] lock_cnt;
        logic locked;
        logic ack;
        logic [31:0] dat;
        logic dbg_out, dbg_oe_n;
    } sccd_state_t;
    sccd_state_t q, next_q;
    logic [PN-1:0] pins, rise;
    logic bus_req, wr_lane0, wake_event;
    logic [ST_WIDTH_L-1:0] status;

    // register offset compare, used only by the checks; decode uses its own case
    function automatic logic wr_to(input logic [7:0] adr,
                                   input logic [7:0] reg_adr,
                                   input logic req);
        return req && (adr == reg_adr);
    endfunction
    // pin vector; every pin is asynchronous to clk
    assign pins[sccd_pkg::PIN_REF_SEL] = ref_source_select_pin;
    assign pins[sccd_pkg::PIN_WAKE] = wake_pin;
    assign pins[sccd_pkg::PIN_EXTERNAL_INTERRUPT_PIN_ZERO] = external_interrupt_pin_zero;
    assign pins[sccd_pkg::PIN_EXTERNAL_INTERRUPT_PIN_ONE] = external_interrupt_pin_one;
    assign pins[sccd_pkg::PIN_RTC_IRQ] = rtc_interrupt;
    assign pins[sccd_pkg::PIN_RTC_OSC] = rtc_osc_present_pin;
    // edges seen only on the second and third stages, never the first
    assign rise = q.s2 & ~q.s3;
    assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    // rtc interrupt only counts when its oscillator is there
    assign wake_event = rise[sccd_pkg::PIN_WAKE] // RQ10
        || rise[sccd_pkg::PIN_EXTERNAL_INTERRUPT_PIN_ZERO]
        || rise[sccd_pkg::PIN_EXTERNAL_INTERRUPT_PIN_ONE]
        || (rise[sccd_pkg::PIN_RTC_IRQ] && q.rtc_ok); // RQ14
    // status word from live state
    always_comb begin
        status = '0;
        status[sccd_pkg::ST_REF_EXTERNAL] = q.ref_ext;
        status[sccd_pkg::ST_BYPASS_ON] = q.byp_en;
        status[sccd_pkg::ST_PLL_ON] = q.pll_en;
        status[sccd_pkg::ST_PLL_LOCKED] = q.locked;
        status[sccd_pkg::ST_MAIN_SYSTEM_CLOCK_STOPPED] = !q.main_en;
        status[sccd_pkg::ST_CPU_GATED] = q.cpu_gated;
        status[sccd_pkg::ST_RTC_OSC_OK] = q.rtc_ok;
    end
    // whole next state
    always_comb begin
        next_q = q;
        next_q.s1 = pins;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // straps caught once after release; later changes are ignored
        if (q.strap_cnt != sccd_pkg::STRAP_DONE) begin
            next_q.strap_cnt = q.strap_cnt + 2'h1;
            next_q.ref_ext = q.s2[sccd_pkg::PIN_REF_SEL]; // RQ1
            next_q.rtc_ok = q.s2[sccd_pkg::PIN_RTC_OSC]; // RQ14
        end
        // wishbone: one wait state, answer registered with the data
        next_q.ack = 1'h0;
        if (bus_req) begin
            next_q.ack = 1'h1;
            next_q.dat = '0;
            unique case (wb_adr_i)
                sccd_pkg::ADR_PLL_CTRL:
                    next_q.dat[sccd_pkg::BIT_PLL_POWERDOWN] = q.pll_pd;
                sccd_pkg::ADR_CLK_CFG:
                    next_q.dat[sccd_pkg::BIT_MAIN_SYSTEM_CLOCK_SOURCE] = q.src_bit;
                sccd_pkg::ADR_PERI_GATE:
                    next_q.dat[sccd_pkg::BIT_MASTER_STOP] = q.master_stop;
                sccd_pkg::ADR_IDLE_CFG:
                    next_q.dat[sccd_pkg::BIT_CPU_IDLE_GATE] = q.idle_bit;
                sccd_pkg::ADR_USB_CTRL:
                    next_q.dat[sccd_pkg::BIT_USB_OSC_EN] = q.usb_en;
                sccd_pkg::ADR_CPU_ST3:
                    next_q.dat[sccd_pkg::BIT_DEBUG_CLOCK_OFF] = q.dbg_off;
                sccd_pkg::ADR_STATUS:
                    next_q.dat[ST_WIDTH_L-1:0] = status;
                default:
                    next_q.dat = '0;
            endcase
        end
        // register writes; power-down is taken even with the pll selected
        if (wr_lane0) begin
            unique case (wb_adr_i)
                sccd_pkg::ADR_PLL_CTRL:
                    next_q.pll_pd =
                        wb_dat_i[sccd_pkg::BIT_PLL_POWERDOWN]; // RQ6 RQ8
                sccd_pkg::ADR_CLK_CFG:
                    next_q.src_bit = wb_dat_i[sccd_pkg::BIT_MAIN_SYSTEM_CLOCK_SOURCE]
                        && !q.pll_pd; // RQ8
                sccd_pkg::ADR_PERI_GATE:
                    next_q.master_stop =
                        wb_dat_i[sccd_pkg::BIT_MASTER_STOP]; // RQ9
                sccd_pkg::ADR_IDLE_CFG:
                    next_q.idle_bit = wb_dat_i[sccd_pkg::BIT_CPU_IDLE_GATE];
                sccd_pkg::ADR_USB_CTRL:
                    next_q.usb_en = wb_dat_i[sccd_pkg::BIT_USB_OSC_EN]; // RQ4
                sccd_pkg::ADR_CPU_ST3:
                    next_q.dbg_off =
                        wb_dat_i[sccd_pkg::BIT_DEBUG_CLOCK_OFF]; // RQ13
                default: ;
            endcase
        end
        // a wake beats a stop write in the same cycle: the clock must run
        if (wake_event) begin
            next_q.master_stop = 1'h0; // RQ10
        end
        // idle gating; an interrupt in the same cycle keeps the cpu running
        if (idle_instruction && q.idle_bit) begin
            next_q.cpu_gated = 1'h1; // RQ11
        end
        if (unmasked_irq) begin
            next_q.cpu_gated = 1'h0; // RQ12
        end
        // lock timer restarts whenever the pll is powered down
        if (q.pll_pd) begin
            next_q.lock_cnt = '0;
            next_q.locked = 1'h0;
        end else if (q.lock_cnt != LOCK_LAST) begin
            next_q.lock_cnt = q.lock_cnt + LW'(1);
        end else begin
            next_q.locked = 1'h1; // RQ16
        end
        // break-before-make: one cycle with both paths off
        unique case (q.mux)
            sccd_pkg::SCCD_MUX_BYPASS:
                if (q.src_bit) next_q.mux = sccd_pkg::SCCD_MUX_TO_PLL;
            sccd_pkg::SCCD_MUX_TO_PLL:
                next_q.mux = sccd_pkg::SCCD_MUX_PLL;
            sccd_pkg::SCCD_MUX_PLL:
                if (!q.src_bit) next_q.mux = sccd_pkg::SCCD_MUX_TO_BYPASS;
            sccd_pkg::SCCD_MUX_TO_BYPASS:
                next_q.mux = sccd_pkg::SCCD_MUX_BYPASS;
            default:
                next_q.mux = sccd_pkg::SCCD_MUX_BYPASS;
        endcase
        // bypass feeds the reference straight on; no usb input exists
        next_q.byp_en = (next_q.mux == sccd_pkg::SCCD_MUX_BYPASS); // RQ3 RQ5
        next_q.pll_en = (next_q.mux == sccd_pkg::SCCD_MUX_PLL); // RQ15
        // gate enables; the cpu gate sits under the master gate
        next_q.main_en = !next_q.master_stop; // RQ9
        next_q.cpu_en = !next_q.master_stop && !next_q.cpu_gated; // RQ11
        // debug pin toggles at half rate; oe_n high floats the pin
        next_q.dbg_oe_n = next_q.dbg_off; // RQ13
        next_q.dbg_out = next_q.dbg_off ? 1'h0 : !q.dbg_out;
    end
    // single state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.pll_pd <= sccd_pkg::RST_PLL_POWERDOWN;
            q.src_bit <= sccd_pkg::RST_MAIN_SYSTEM_CLOCK_SOURCE;
            q.master_stop <= sccd_pkg::RST_MASTER_STOP;
            q.idle_bit <= sccd_pkg::RST_CPU_IDLE_GATE;
            q.usb_en <= sccd_pkg::RST_USB_OSC_EN;
            q.dbg_off <= sccd_pkg::RST_DEBUG_CLOCK_OFF;
            q.dbg_oe_n <= sccd_pkg::RST_DEBUG_CLOCK_OFF;
            q.mux <= sccd_pkg::SCCD_MUX_BYPASS;
            q.byp_en <= 1'h1;
            q.main_en <= 1'h1;
            q.cpu_en <= 1'h1;
        end else begin
            q <= next_q;
        end
    end
    // outputs straight from the state register
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign ref_from_external = q.ref_ext;
    assign bypass_clock_enable = q.byp_en;
    assign pll_clock_enable = q.pll_en;
    assign pll_powerdown = q.pll_pd;
    assign pll_locked = q.locked;
    assign usb_osc_enable = q.usb_en;
    assign rtc_run = q.rtc_ok;
    assign main_clock_enable = q.main_en;
    assign cpu_clock_enable = q.cpu_en;
    assign debug_clock_pin_o = q.dbg_out;
    assign debug_clock_pin_oe_n = q.dbg_oe_n;
    // gated clock trees; the bus keeps the ungated root clock
    sccd_clock_gate u_main_gate (
        .clk_in(clk),
        .enable(q.main_en),
        .clk_out(main_system_clock)
    );
    sccd_clock_gate u_cpu_gate (
        .clk_in(clk),
        .enable(q.cpu_en),
        .clk_out(cpu_clock)
    );
    // checks
    property p_failsafe;
        (q.pll_pd && wr_to(wb_adr_i, sccd_pkg::ADR_CLK_CFG, wr_lane0))
            |=> !q.src_bit;
    endproperty
    a_failsafe: assert property (p_failsafe) // RQ8
        else $error("pll selected while powered down");
    property p_powerdown;
        (wr_to(wb_adr_i, sccd_pkg::ADR_PLL_CTRL, wr_lane0)
            && wb_dat_i[sccd_pkg::BIT_PLL_POWERDOWN]) |=> pll_powerdown;
    endproperty
    a_powerdown: assert property (p_powerdown) // RQ6
        else $error("pll power-down write not taken");
    sequence s_break_to_pll;
        !bypass_clock_enable && !pll_clock_enable ##1 pll_clock_enable;
    endsequence
    property p_mux_break;
        (bypass_clock_enable && q.src_bit) |=> s_break_to_pll;
    endproperty
    a_mux_break: assert property (p_mux_break) // RQ15
        else $error("mux switched without a dead cycle");
    property p_mux_excl;
        !(bypass_clock_enable && pll_clock_enable);
    endproperty
    a_mux_excl: assert property (p_mux_excl) // RQ3
        else $error("bypass and pll paths both enabled");
    property p_stop;
        (wr_to(wb_adr_i, sccd_pkg::ADR_PERI_GATE, wr_lane0)
            && wb_dat_i[sccd_pkg::BIT_MASTER_STOP] && !wake_event)
            |=> !main_clock_enable && !cpu_clock_enable;
    endproperty
    a_stop: assert property (p_stop) // RQ9
        else $error("master stop did not halt the clock");
    sequence s_wake;
        q.master_stop && rise[sccd_pkg::PIN_WAKE];
    endsequence
    property p_wake;
        s_wake |=> main_clock_enable;
    endproperty
    a_wake: assert property (p_wake) // RQ10
        else $error("wake pin did not restart the clock");
    property p_rtc_dead;
        (!q.rtc_ok && q.master_stop && !wake_event && !wr_lane0)
            |=> !main_clock_enable;
    endproperty
    a_rtc_dead: assert property (p_rtc_dead) // RQ14
        else $error("clock woke without a valid source");
    property p_idle;
        (idle_instruction && q.idle_bit && !unmasked_irq && q.main_en
            && !wr_lane0 && !wake_event)
            |=> !cpu_clock_enable && main_clock_enable;
    endproperty
    a_idle: assert property (p_idle) // RQ11
        else $error("idle gating wrong");
    property p_irq;
        (q.cpu_gated && unmasked_irq && !q.master_stop && !wr_lane0)
            |=> cpu_clock_enable;
    endproperty
    a_irq: assert property (p_irq) // RQ12
        else $error("interrupt did not restore the cpu clock");
    property p_usb;
        $rose(usb_osc_enable)
            |-> $past(wr_to(wb_adr_i, sccd_pkg::ADR_USB_CTRL, wr_lane0));
    endproperty
    a_usb: assert property (p_usb) // RQ4
        else $error("usb oscillator started without a write");
    property p_debug;
        (wr_to(wb_adr_i, sccd_pkg::ADR_CPU_ST3, wr_lane0)
            && wb_dat_i[sccd_pkg::BIT_DEBUG_CLOCK_OFF])
            |=> debug_clock_pin_oe_n && !debug_clock_pin_o;
    endproperty
    a_debug: assert property (p_debug) // RQ13
        else $error("debug clock pin still driven");
endmodule // sccd_top
`default_nettype wire

/* File: tb/sccd_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sccd_top_tb;
    // short lock count keeps the run brief
    localparam int LOCK = 16;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [3:0] s;
        logic [31:0] d;
        logic [31:0] e;
    } sccd_tb_row_t;
    logic clk, reset, cyc, stb, we, ref_sel, rtc_osc, ack, a;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rd, dat_o;
    // 0 wake, 1 external_interrupt_pin_zero, 2 external_interrupt_pin_one, 3 rtc irq, 4 idle instr, 5 unmasked irq
    logic [5:0] pv;
    logic ref_ext, byp_en, pll_en, pll_pd, pll_lk, usb_en, rtc_run;
    logic main_en, cpu_en, msc, cpuc, dbg_o, dbg_oe_n;
    int err_count, checks, cycles, i, n;
    sccd_tb_row_t rows [13] = '{
        '{1'b0, sccd_pkg::ADR_PLL_CTRL, 4'h1, 32'h0, 32'h1},
        '{1'b0, sccd_pkg::ADR_CLK_CFG, 4'h1, 32'h0, 32'h0},
        '{1'b0, sccd_pkg::ADR_PERI_GATE, 4'h1, 32'h0, 32'h0},
        '{1'b0, sccd_pkg::ADR_IDLE_CFG, 4'h1, 32'h0, 32'h0},
        '{1'b0, sccd_pkg::ADR_USB_CTRL, 4'h1, 32'h0, 32'h0},
        '{1'b0, sccd_pkg::ADR_CPU_ST3, 4'h1, 32'h0, 32'h0},
        '{1'b1, sccd_pkg::ADR_USB_CTRL, 4'h1, 32'hffffffff, 32'h0},
        '{1'b1, sccd_pkg::ADR_USB_CTRL, 4'he, 32'h0, 32'h0},
        '{1'b0, sccd_pkg::ADR_USB_CTRL, 4'h1, 32'h0, 32'h1},
        '{1'b1, 8'h1c, 4'h1, 32'h1, 32'h0},
        '{1'b0, 8'h1c, 4'h1, 32'h0, 32'h0},
        '{1'b1, sccd_pkg::ADR_CLK_CFG, 4'h1, 32'h1, 32'h0},
        '{1'b0, sccd_pkg::ADR_CLK_CFG, 4'h1, 32'h0, 32'h0}
    };

    sccd_top #(.LOCK_CYCLES(LOCK)) dut (
        .clk(clk), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ref_source_select_pin(ref_sel), .rtc_osc_present_pin(rtc_osc),
        .wake_pin(pv[0]), .external_interrupt_pin_zero(pv[1]),
        .external_interrupt_pin_one(pv[2]), .rtc_interrupt(pv[3]),
        .idle_instruction(pv[4]), .unmasked_irq(pv[5]),
        .ref_from_external(ref_ext), .bypass_clock_enable(byp_en),
        .pll_clock_enable(pll_en), .pll_powerdown(pll_pd),
        .pll_locked(pll_lk), .usb_osc_enable(usb_en), .rtc_run(rtc_run),
        .main_clock_enable(main_en), .cpu_clock_enable(cpu_en),
        .main_system_clock(msc), .cpu_clock(cpuc),
        .debug_clock_pin_o(dbg_o), .debug_clock_pin_oe_n(dbg_oe_n)
    );

    // free-running 125 mhz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            $display("[FAIL] run length expected below 6000 seen 6000");
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    // wait k edges, then let the edge's updates settle
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] s,
                      input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        sel <= s;
        wd <= d;
        @(posedge clk);
        while (ack !== 1'b1 && t < 20) begin
            t++;
            @(posedge clk);
        end
        if (t == 20) begin
            err_count++;
            $display("[FAIL] ack expected 1 seen none");
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // one-cycle pulse on an event input
    task automatic pulse(input int k);
        @(posedge clk);
        pv[k] <= 1'b1;
        @(posedge clk);
        pv[k] <= 1'b0;
        tick(1);
    endtask

    // straps change only while reset is held
    task automatic do_reset(input logic rs, input logic ro);
        @(posedge clk);
        reset <= 1'b1;
        ref_sel <= rs;
        rtc_osc <= ro;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        tick(4);
    endtask

    initial begin
        {reset, cyc, stb, we, a} = 5'h10;
        {adr, sel, wd, pv} = '0;
        ref_sel = 1'b1;
        rtc_osc = 1'b1;
        err_count = 0;
        checks = 0;
        cycles = 0;
        do_reset(1'b1, 1'b1);
        chk1("ref external", 1'b1, ref_ext);
        chk1("bypass", 1'b1, byp_en);
        chk1("pll path", 1'b0, pll_en);
        chk1("pll off", 1'b1, pll_pd);
        chk1("usb osc", 1'b0, usb_en);
        chk1("debug oe_n", 1'b0, dbg_oe_n);
        chk1("rtc run", 1'b1, rtc_run);
        wb(1'b0, sccd_pkg::ADR_STATUS, 4'h1, 32'h0);
        chk1("status ext", 1'b1, rd[sccd_pkg::ST_REF_EXTERNAL]);
        chk1("status rtc", 1'b1, rd[sccd_pkg::ST_RTC_OSC_OK]);
        $display("test reset done");
        // register table: reset values, lanes, unmapped place, refusal
        for (i = 0; i < 13; i++) begin
            wb(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
            if (!rows[i].w)
                chk($sformatf("row %0d", i), rows[i].e, rd);
        end
        tick(1);
        chk1("usb osc on", 1'b1, usb_en);
        chk1("refused pll", 1'b0, pll_en);
        $display("test registers done");
        // debug pin toggles, then floats when switched off
        a = dbg_o;
        tick(1);
        chk1("debug toggle", ~a, dbg_o);
        wb(1'b1, sccd_pkg::ADR_CPU_ST3, 4'h1, 32'h1);
        tick(1);
        chk1("debug off oe_n", 1'b1, dbg_oe_n);
        chk1("debug off pin", 1'b0, dbg_o);
        $display("test debug done");
        // power up, lock, switch to pll without overlap
        wb(1'b1, sccd_pkg::ADR_PLL_CTRL, 4'h1, 32'h0);
        tick(LOCK + 4);
        chk1("pll on", 1'b0, pll_pd);
        chk1("pll lock", 1'b1, pll_lk);
        wb(1'b1, sccd_pkg::ADR_CLK_CFG, 4'h1, 32'h1);
        for (i = 0; i < 6; i++) begin
            chk1("mux overlap", 1'b0, byp_en & pll_en);
            tick(1);
        end
        chk1("pll selected", 1'b1, pll_en);
        chk1("bypass off", 1'b0, byp_en);
        chk1("clock runs", 1'b1, msc);
        // power-down of a selected pll is not blocked
        wb(1'b1, sccd_pkg::ADR_PLL_CTRL, 4'h1, 32'h1);
        tick(2);
        chk1("pll down", 1'b1, pll_pd);
        wb(1'b1, sccd_pkg::ADR_CLK_CFG, 4'h1, 32'h0);
        tick(6);
        chk1("bypass back", 1'b1, byp_en);
        $display("test mux done");
        // master stop, restarted by each wake source in turn
        for (i = 0; i < 4; i++) begin
            wb(1'b1, sccd_pkg::ADR_PERI_GATE, 4'h1, 32'h1);
            tick(2);
            chk1("main stopped", 1'b0, main_en);
            chk1("cpu stopped", 1'b0, cpu_en);
            chk1("gated clock low", 1'b0, msc);
            pulse(i);
            n = 0;
            while (main_en !== 1'b1 && n < 10) begin
                n++;
                tick(1);
            end
            chk1($sformatf("wake %0d", i), 1'b1, main_en);
            chk1("cpu back", 1'b1, cpu_en);
        end
        $display("test wake done");
        // idle gates the cpu only, an unmasked irq restores it
        wb(1'b1, sccd_pkg::ADR_IDLE_CFG, 4'h1, 32'h1);
        pulse(4);
        tick(4);
        chk1("cpu gated", 1'b0, cpu_en);
        chk1("cpu clock low", 1'b0, cpuc);
        chk1("main kept", 1'b1, msc);
        pulse(5);
        tick(1);
        chk1("irq restores", 1'b1, cpu_en);
        wb(1'b1, sccd_pkg::ADR_IDLE_CFG, 4'h1, 32'h0);
        pulse(4);
        tick(2);
        chk1("idle bit clear", 1'b1, cpu_en);
        $display("test idle done");
        // second reset with other straps: rtc oscillator absent
        do_reset(1'b0, 1'b0);
        chk1("ref rtc osc", 1'b0, ref_ext);
        chk1("rtc stopped", 1'b0, rtc_run);
        chk1("usb reset", 1'b0, usb_en);
        wb(1'b1, sccd_pkg::ADR_PERI_GATE, 4'h1, 32'h1);
        pulse(3);
        tick(6);
        chk1("rtc irq ignored", 1'b0, main_en);
        pulse(0);
        tick(6);
        chk1("wake pin", 1'b1, main_en);
        $display("test second reset done");
        results();
    end
endmodule // sccd_top_tb
`default_nettype wire
